// ==== verilog/phy_ctl_pkg.sv ====
// Constants, types and register map of the PHY control register block
package phy_ctl_pkg;

  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned STRETCH_MS = 50;
  localparam int unsigned STRETCH_CYCLES =
    STRETCH_MS * (CLK_HZ / 1000);

  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_PHY_CONTROL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS  = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR   = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE  = 5'h0c;

  localparam int BIT_PAUSE_RX     = 13;
  localparam int BIT_PAUSE_TX     = 12;
  localparam int BIT_INJECT       = 11;
  localparam int BIT_LONG_SEQ     = 10;
  localparam int BIT_PASS         = 9;
  localparam int BIT_RUN          = 8;
  localparam int BIT_STRETCH_SKIP = 7;
  localparam int BIT_LED_STYLE    = 5;

  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
  localparam logic             RST_CTL = 1'b0;
  localparam logic [14:0]      PRBS_SEED = 15'h7fff;
  localparam logic [3:0]       PRIME_LAST = 4'he;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PRIME = 3'b010,
    ST_CHECK = 3'b100
  } selftest_state_t;

  // Advertised ability bits 11:10
  typedef struct packed {
    logic asm_dir;
    logic pause;
  } pause_adv_t;

  typedef struct packed {
    logic link_change;
    logic pause_change;
    logic selftest_fail;
  } irq_bits_t;

endpackage

// ==== verilog/phy_control_selftest_led.sv ====
// PHY control register: pause flags, packet self-test and LED control
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps

module phy_control_selftest_led
  import phy_ctl_pkg::*;
#(
  parameter int unsigned STRETCH_LEN = STRETCH_CYCLES
)(
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire pause_adv_t        local_ability_advert_i,
  input  wire pause_adv_t        partner_ability_advert_i,
  input  wire logic              hcd_full_duplex_i,
  input  wire logic              link_good_i,
  input  wire logic              activity_i,
  input  wire logic              led_style_strap_i,
  output logic                   pause_rx_o,
  output logic                   pause_tx_o,
  output logic                   link_indicator_pin_o,
  output logic                   irq_o
);

  localparam int SW = $clog2(STRETCH_LEN + 1);
  localparam logic [SW-1:0] S_LEN  = SW'(STRETCH_LEN);
  localparam logic [SW-1:0] S_HALF = SW'(STRETCH_LEN / 2);

  logic              wait_r;
  logic [31:0]       rdata_r;
  logic [31:0]       rd_nxt;
  logic [15:0]       ctl_view;
  logic [ADDR_W-1:0] addr;
  logic              wr_acc;
  logic              ctl_wr_hi;
  logic              ctl_wr_lo;
  logic [7:0]        wd_lo;
  logic [7:0]        wd_hi;

  logic            run_r;
  logic            long_seq_r;
  logic            stretch_skip_r;
  logic            led_style_r;
  logic            inject_r;
  logic            pass_r;
  logic            strap_meta_r;
  logic            strap_sync_r;
  logic            strap_done_r;

  selftest_state_t st_r;
  logic [3:0]      prime_cnt_r;
  logic            long_seq_d_r;
  logic [14:0]     gen_r;
  logic [14:0]     chk_r;
  logic            gen_bit;
  logic            tx_bit;
  logic            expect_bit;
  logic            inject_fire;
  logic            err;

  logic            pause_rx_nxt;
  logic            pause_tx_nxt;
  logic [SW-1:0]   act_cnt_r;
  logic            blink_off;
  logic            led_nxt;
  logic            link_d_r;

  irq_bits_t       irq_status_r;
  irq_bits_t       irq_enable_r;
  irq_bits_t       irq_event;
  logic            irq_r;

  // Bus decode, one wait state on every access
  assign addr      = {avs_address_i[ADDR_W-1:2], 2'b00};
  assign wr_acc    = avs_write_i & ~wait_r;
  assign ctl_wr_hi = wr_acc & (addr == OFF_PHY_CONTROL)
                   & avs_byteenable_i[1];
  assign ctl_wr_lo = wr_acc & (addr == OFF_PHY_CONTROL)
                   & avs_byteenable_i[0];
  assign wd_lo     = avs_writedata_i[7:0];
  assign wd_hi     = avs_writedata_i[15:8];

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wait_r <= 1'b1;
    end else if ((avs_read_i | avs_write_i) & wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_comb begin
    ctl_view = 16'h0000;
    ctl_view[BIT_PAUSE_RX]     = pause_rx_o;
    ctl_view[BIT_PAUSE_TX]     = pause_tx_o;
    ctl_view[BIT_INJECT]       = inject_r;
    ctl_view[BIT_LONG_SEQ]     = long_seq_r;
    ctl_view[BIT_PASS]         = pass_r;
    ctl_view[BIT_RUN]          = run_r;
    ctl_view[BIT_STRETCH_SKIP] = stretch_skip_r;
    ctl_view[BIT_LED_STYLE]    = led_style_r;
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (addr)
      OFF_PHY_CONTROL: rd_nxt[15:0]      = ctl_view;
      OFF_IRQ_STATUS:  rd_nxt[IRQ_W-1:0] = irq_status_r;
      OFF_IRQ_ENABLE:  rd_nxt[IRQ_W-1:0] = irq_enable_r;
      default:         rd_nxt            = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i & wait_r) begin
      rdata_r <= rd_nxt;
    end
  end

  // Writable control bits; bit 6 is not stored
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      run_r          <= RST_CTL;
      long_seq_r     <= RST_CTL;
      stretch_skip_r <= RST_CTL;
    end else begin
      if (ctl_wr_hi) begin
        run_r      <= wd_hi[BIT_RUN-8];
        long_seq_r <= wd_hi[BIT_LONG_SEQ-8];
      end
      if (ctl_wr_lo) begin
        stretch_skip_r <= wd_lo[BIT_STRETCH_SKIP];
      end
    end
  end

  // Strap pin synchroniser
  always_ff @(posedge mclk_i) begin
    strap_meta_r <= led_style_strap_i;
    strap_sync_r <= strap_meta_r;
  end

  // LED style loads from the strap after reset, then software owns it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      led_style_r  <= RST_CTL;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      led_style_r  <= strap_sync_r;
      strap_done_r <= 1'b1;
    end else if (ctl_wr_lo) begin
      led_style_r  <= wd_lo[BIT_LED_STYLE];
    end
  end

  // Self-clearing inject request
  assign inject_fire = inject_r & (st_r == ST_CHECK);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      inject_r <= RST_CTL;
    end else if (ctl_wr_hi && wd_hi[BIT_INJECT-8]) begin
      inject_r <= 1'b1;
    end else if (inject_fire) begin
      inject_r <= 1'b0;
    end else if (!run_r) begin
      inject_r <= 1'b0;
    end
  end

  // Self-test sequencing; a sequence change re-primes the checker
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r         <= ST_IDLE;
      prime_cnt_r  <= 4'h0;
      long_seq_d_r <= RST_CTL;
    end else begin
      long_seq_d_r <= long_seq_r;
      case (st_r)
        ST_IDLE: begin
          prime_cnt_r <= 4'h0;
          if (run_r) begin
            st_r <= ST_PRIME;
          end
        end
        ST_PRIME: begin
          prime_cnt_r <= prime_cnt_r + 4'h1;
          if (!run_r) begin
            st_r <= ST_IDLE;
          end else if (prime_cnt_r == PRIME_LAST) begin
            st_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          prime_cnt_r <= 4'h0;
          if (!run_r) begin
            st_r <= ST_IDLE;
          end else if (long_seq_r != long_seq_d_r) begin
            st_r <= ST_PRIME;
          end
        end
        default: begin
          st_r        <= ST_IDLE;
          prime_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // Pattern generator and self-synchronising checker on an internal loop
  assign gen_bit = long_seq_r ? gen_r[14] ^ gen_r[13]
                              : gen_r[8] ^ gen_r[4];
  assign tx_bit  = gen_bit ^ inject_fire;
  assign expect_bit = long_seq_r ? chk_r[14] ^ chk_r[13]
                                 : chk_r[8] ^ chk_r[4];
  assign err     = (st_r == ST_CHECK) & (tx_bit != expect_bit);

  always_ff @(posedge mclk_i) begin
    if (reset_i || st_r == ST_IDLE) begin
      gen_r <= PRBS_SEED;
      chk_r <= 15'h0000;
    end else begin
      gen_r <= {gen_r[13:0], gen_bit};
      chk_r <= {chk_r[13:0], tx_bit};
    end
  end

  // Pass flag: set on start, latched low on error, cleared on stop
  always_ff @(posedge mclk_i) begin
    if (reset_i || !run_r) begin
      pass_r <= 1'b0;
    end else if (st_r == ST_IDLE) begin
      pass_r <= 1'b1;
    end else if (err) begin
      pass_r <= 1'b0;
    end
  end

  // Pause resolution, only for a full duplex common mode
  assign pause_rx_nxt = hcd_full_duplex_i & (
    (local_ability_advert_i.pause & partner_ability_advert_i.pause) |
    (local_ability_advert_i.pause & local_ability_advert_i.asm_dir &
     ~partner_ability_advert_i.pause &
     partner_ability_advert_i.asm_dir));
  assign pause_tx_nxt = hcd_full_duplex_i & (
    (local_ability_advert_i.pause & partner_ability_advert_i.pause) |
    (~local_ability_advert_i.pause & local_ability_advert_i.asm_dir &
     partner_ability_advert_i.pause &
     partner_ability_advert_i.asm_dir));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pause_rx_o <= 1'b0;
      pause_tx_o <= 1'b0;
    end else begin
      pause_rx_o <= pause_rx_nxt;
      pause_tx_o <= pause_tx_nxt;
    end
  end

  // Activity stretch: off for the first half, on for the second
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      act_cnt_r <= '0;
    end else if (act_cnt_r == '0) begin
      if (activity_i) begin
        act_cnt_r <= S_LEN;
      end
    end else begin
      act_cnt_r <= act_cnt_r - SW'(1);
    end
  end

  assign blink_off = act_cnt_r > S_HALF;
  assign led_nxt   = link_good_i & ~(~led_style_r &
                     (stretch_skip_r ? activity_i : blink_off));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      link_indicator_pin_o <= 1'b0;
      link_d_r             <= 1'b0;
    end else begin
      link_indicator_pin_o <= led_nxt;
      link_d_r             <= link_good_i;
    end
  end

  // Interrupt status, clear and enable
  assign irq_event.selftest_fail = err & pass_r;
  assign irq_event.pause_change  = (pause_rx_nxt != pause_rx_o) |
                                   (pause_tx_nxt != pause_tx_o);
  assign irq_event.link_change   = link_good_i != link_d_r;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_status_r <= RST_IRQ;
    end else if (wr_acc && addr == OFF_IRQ_CLEAR &&
                 avs_byteenable_i[0]) begin
      irq_status_r <= (irq_status_r & ~wd_lo[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status_r <= irq_status_r | irq_event;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_enable_r <= RST_IRQ;
    end else if (wr_acc && addr == OFF_IRQ_ENABLE &&
                 avs_byteenable_i[0]) begin
      irq_enable_r <= wd_lo[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_r & irq_enable_r);
    end
  end

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign irq_o             = irq_r;

  pause_rx_only_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    hcd_full_duplex_i && local_ability_advert_i == 2'b11 &&
    partner_ability_advert_i == 2'b10
    |=> pause_rx_o && !pause_tx_o)
    else $error("pause receive not resolved");

  pause_tx_only_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    hcd_full_duplex_i && local_ability_advert_i == 2'b10 &&
    partner_ability_advert_i == 2'b11
    |=> pause_tx_o && !pause_rx_o)
    else $error("pause transmit not resolved");

  pause_duplex_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    !hcd_full_duplex_i |=> !pause_rx_o && !pause_tx_o)
    else $error("pause flag set without full duplex");

  inject_once_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    inject_fire && pass_r && run_r
    |=> !inject_r && !pass_r && run_r)
    else $error("inject did not fail the test or stay set");

  pass_start_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    $rose(run_r) |=> pass_r ##1 st_r == ST_PRIME)
    else $error("self-test start not reported");

  pass_stop_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    !run_r |=> !pass_r && st_r != ST_CHECK)
    else $error("pass flag kept after stop");

  stretch_skip_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    stretch_skip_r && !led_style_r && activity_i
    |=> !link_indicator_pin_o)
    else $error("bypass did not follow activity");

  style_link_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    strap_done_r && led_style_r
    |=> link_indicator_pin_o == $past(link_good_i))
    else $error("link LED not following link");

  style_blink_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    !led_style_r && !stretch_skip_r && act_cnt_r == '0 &&
    activity_i ##1 !led_style_r && !stretch_skip_r
    |=> !link_indicator_pin_o)
    else $error("link LED did not blink on activity");

  inject_idle_a: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    inject_r && !run_r && !ctl_wr_hi |=> !inject_r)
    else $error("inject kept while stopped");

endmodule

// ==== verification/mac_partner.sv ====
// MAC side model: sends frames that show up as link activity
`timescale 1ns/1ps
module mac_partner #(
  parameter int FRAME_LEN = 1
)(
  input  wire logic mclk_i,
  input  wire logic go_i,
  output logic      activity_o
);
  int left = 0;
  // One frame per request, ignored while a frame is still going
  always @(posedge mclk_i) begin
    if (go_i && left == 0) begin
      left <= FRAME_LEN;
    end else if (left != 0) begin
      left <= left - 1;
    end
  end
  assign activity_o = (left != 0);
endmodule

// ==== verification/tb_phy_control_selftest_led.sv ====
// Testbench for the PHY control register block
`timescale 1ns/1ps
module tb_phy_control_selftest_led
  import phy_ctl_pkg::*;
;
  logic              mclk = 1'b0;
  logic              rst  = 1'b1;
  logic              rd   = 1'b0;
  logic              wr   = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0]       wdata = '0;
  logic [31:0]       rdata;
  logic [31:0]       rv;
  logic              wreq;
  pause_adv_t        loc = '0;
  pause_adv_t        prt = '0;
  logic              fd   = 1'b0;
  logic              link = 1'b0;
  logic              go   = 1'b0;
  logic              strap = 1'b1;
  logic              act;
  logic              prx;
  logic              ptx;
  logic              led;
  logic              irq;
  int                error_cnt = 0;
  int                checks_done = 0;
  int                cyc = 0;

  always #25 mclk = ~mclk;

  phy_control_selftest_led #(.STRETCH_LEN(8)) i_dut (
    .mclk_i                   (mclk),
    .reset_i                  (rst),
    .avs_address_i            (addr),
    .avs_read_i               (rd),
    .avs_write_i              (wr),
    .avs_writedata_i          (wdata),
    .avs_byteenable_i         (4'h3),
    .avs_readdata_o           (rdata),
    .avs_waitrequest_o        (wreq),
    .local_ability_advert_i   (loc),
    .partner_ability_advert_i (prt),
    .hcd_full_duplex_i        (fd),
    .link_good_i              (link),
    .activity_i               (act),
    .led_style_strap_i        (strap),
    .pause_rx_o               (prx),
    .pause_tx_o               (ptx),
    .link_indicator_pin_o     (led),
    .irq_o                    (irq)
  );

  mac_partner #(.FRAME_LEN(1)) i_mac (
    .mclk_i     (mclk),
    .go_i       (go),
    .activity_o (act)
  );

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    do @(posedge mclk); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    do @(posedge mclk); while (wreq !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    chk(rv, e);
  endtask

  task automatic wait_led(input logic v, input int n);
    do begin
      @(posedge mclk);
      n--;
    end while (led !== v && n > 0);
    chk({31'h0, led}, {31'h0, v});
  endtask

  task automatic frame;
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask

  // Standard pause resolution, {rx, tx}; v = {fd, asm_l, pause_l, asm_p, pause_p}
  function automatic logic [1:0] pause_exp(input logic [4:0] v);
    logic rx;
    logic tx;
    rx = v[2] & v[0] | v[2] & v[3] & ~v[0] & v[1];
    tx = v[2] & v[0] | ~v[2] & v[3] & v[0] & v[1];
    return {rx, tx} & {2{v[4]}};
  endfunction

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  end

  initial begin
    logic [1:0] pe;
    repeat (4) @(posedge mclk);
    rst  <= 1'b0;
    link <= 1'b1;
    rd_chk(OFF_PHY_CONTROL, 32'h0020);
    rd_chk(5'h10, 32'h0);
    rd_chk(OFF_IRQ_CLEAR, 32'h0);
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk);
      fd  <= i[4];
      loc <= i[3:2];
      prt <= i[1:0];
      pe = pause_exp(i[4:0]);
      repeat (2) @(posedge mclk);
      chk({30'h0, prx, ptx}, {30'h0, pe});
      rd_chk(OFF_PHY_CONTROL, {18'h0, pe, 12'h020});
    end
    @(posedge mclk);
    loc <= '0;
    repeat (3) @(posedge mclk);
    rd_chk(OFF_IRQ_STATUS, 32'h6);
    bus_wr(OFF_IRQ_CLEAR, 32'h7);
    rd_chk(OFF_IRQ_STATUS, 32'h0);
    bus_wr(OFF_IRQ_ENABLE, 32'h1);
    rd_chk(OFF_IRQ_ENABLE, 32'h1);
    bus_wr(OFF_PHY_CONTROL, 32'h0120);
    repeat (20) @(posedge mclk);
    rd_chk(OFF_PHY_CONTROL, 32'h0320);
    chk({31'h0, irq}, 32'h0);
    bus_wr(OFF_PHY_CONTROL, 32'h0920);
    repeat (5) @(posedge mclk);
    rd_chk(OFF_PHY_CONTROL, 32'h0120);
    rd_chk(OFF_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus_wr(OFF_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    bus_wr(OFF_IRQ_CLEAR, 32'h1);
    rd_chk(OFF_IRQ_STATUS, 32'h0);
    bus_wr(OFF_PHY_CONTROL, 32'h0020);
    repeat (2) @(posedge mclk);
    rd_chk(OFF_PHY_CONTROL, 32'h0020);
    bus_wr(OFF_PHY_CONTROL, 32'h0820);
    repeat (2) @(posedge mclk);
    rd_chk(OFF_PHY_CONTROL, 32'h0020);
    bus_wr(OFF_PHY_CONTROL, 32'h0520);
    repeat (20) @(posedge mclk);
    rd_chk(OFF_PHY_CONTROL, 32'h0720);
    rd_chk(OFF_IRQ_STATUS, 32'h0);
    bus_wr(OFF_PHY_CONTROL, 32'h0020);
    frame();
    repeat (4) @(posedge mclk);
    chk({31'h0, led}, 32'h1);
    link <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, led}, 32'h0);
    link <= 1'b1;
    bus_wr(OFF_PHY_CONTROL, 32'h0080);
    frame();
    wait_led(1'b0, 4);
    @(posedge mclk);
    chk({31'h0, led}, 32'h1);
    bus_wr(OFF_PHY_CONTROL, 32'h0000);
    repeat (4) @(posedge mclk);
    frame();
    wait_led(1'b0, 5);
    @(posedge mclk);
    chk({31'h0, led}, 32'h0);
    wait_led(1'b1, 14);
    strap <= 1'b0;
    rst   <= 1'b1;
    repeat (4) @(posedge mclk);
    rst   <= 1'b0;
    rd_chk(OFF_PHY_CONTROL, 32'h0000);
    tally_and_finish;
  end
endmodule
